// [hw/lcs_consts.svh]
// Purpose: constants of the link control state context store
// Assumes: included by its bare name
// Notes:   offsets are word numbers in paddr[3:2] on the APB register bus
`ifndef LCS_CONSTS_SVH
`define LCS_CONSTS_SVH

// ==========================================================================
// sizes
`define LCS_NUM_PRIO      4
`define LCS_PRIO_W        2
`define LCS_NUM_STN       256
`define LCS_ADR_W         8
`define LCS_NUM_INIT      4
`define LCS_NUM_RESP      4
`define LCS_IDX_W         2
`define LCS_NUM_SVC       3
`define LCS_SAP_W         7
`define LCS_TYPE_W        7
`define LCS_SC_W          3
`define LCS_STAT_W        8
`define LCS_LEN_W         8
`define LCS_AREA_W        4

// ==========================================================================
// service bit positions in enable masks and length words
`define LCS_SVC_ACK       0
`define LCS_SVC_NOACK     1
`define LCS_SVC_REQREPLY  2

// ==========================================================================
// register map: region in paddr[11:8], index in [5:4], word in [3:2]
`define LCS_RGN_GLOBAL    4'h0
`define LCS_RGN_INIT      4'h1
`define LCS_RGN_RESP      4'h2
`define LCS_OFF_STATUS    2'h0
`define LCS_OFF_RXHIST    2'h1
`define LCS_OFF_LASTSTAT  2'h2
`define LCS_REG_CTX       2'h0
`define LCS_REG_CTXCLR    2'h1
`define LCS_REG_ICFG      2'h2
`define LCS_REG_ILEN      2'h3
`define LCS_REG_RCFG      2'h0
`define LCS_REG_RLEN      2'h1
`define LCS_REG_SEM       2'h2

// ==========================================================================
// field positions
`define LCS_CTX_DSAP_LSB  8
`define LCS_CTX_RA_LSB    16
`define LCS_CTX_SC_LSB    24
`define LCS_CTX_PRIO_LSB  28
`define LCS_CTX_VALID_BIT 31
`define LCS_RCFG_AREA_LSB 8
`define LCS_RCFG_REPLY_NOTIFY_ACCESS_POINT_LSB 16

// ==========================================================================
// reset value and command/response bit values
`define LCS_SEQ_INIT      4'h0
`define LCS_CR_COMMAND    1'b0
`define LCS_CR_RESPONSE   1'b1

`endif

// [hw/lcs_pkg.sv]
// Purpose: types of the link control state context store
// Assumes: lcs_consts.svh on the include path
// Notes:   numbers live in the header, types here
`include "lcs_consts.svh"

package lcs_pkg;

  typedef enum logic [1:0] {
    TX_INIT,
    TX_IDLE,
    TX_READ
  } lcs_tx_state_t;

  typedef logic [`LCS_ADR_W-1:0]  lcs_addr_t;
  typedef logic [`LCS_SAP_W-1:0]  lcs_sap_t;
  typedef logic [`LCS_PRIO_W-1:0] lcs_prio_t;

endpackage : lcs_pkg

// [hw/lcs_seq_mem.sv]
// Purpose: per-station sequence bit memory, one word per station
// Assumes: one write and one read port, same clock
// Notes:   contents are not reset; the owner sweeps them after reset
`timescale 1ns/1ps
`include "lcs_consts.svh"

module lcs_seq_mem
  import lcs_pkg::*;
(
  input  wire logic                    i_clk,
  input  wire logic                    i_we,
  input  wire lcs_addr_t               i_waddr,
  input  wire logic [`LCS_NUM_PRIO-1:0] i_wdata,
  input  wire logic                    i_re,
  input  wire lcs_addr_t               i_raddr,
  output logic      [`LCS_NUM_PRIO-1:0] o_rdata
);

  logic [`LCS_NUM_PRIO-1:0] mem_ff [`LCS_NUM_STN];

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem_ff[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_re) begin
      o_rdata <= mem_ff[i_raddr];
    end
  end

endmodule : lcs_seq_mem

// [hw/lcs_top.sv]
// Purpose: state and configuration store of a token-bus link control
// Assumes: frame side ports driven by logic on i_clk; APB slave
// Notes:   ready stays low for the 256-cycle sequence sweep after reset
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "lcs_consts.svh"

// Function
// - sequence bit is one boolean bit, only 0 or 1
// - receive history holds type, source, priority, sequence of last frame
// - last response status kept from latest transmitted response
// - global stores exist once per station, shared by all machines
// - each initiator keeps its request context, fields readable singly; here read only together as one context word
// - transmit sequence table: last bit per station and priority
// - each responder has a busy/not busy semaphore guarding reply area
// - exactly four transmission priorities supported
// - at most 256 remote stations tracked for sequencing
// - each initiator holds its management-enabled initiator services
// - each initiator holds maximum data length per enabled service
// - each responder holds enabled services and their maximum lengths
// - each responder records its bound shared data area
// - each responder records its reply notify access point
// - initiator active when any initiator service of it is enabled
// - duplicate only when type, source, priority and sequence all match
// - data area request is test-and-set on the semaphore
// - command frame: sequence merged into type, command/response bit 0
// - response frame: command/response bit set to 1
module lcs_top
  import lcs_pkg::*;
(
  input  wire logic                      i_clk,
  input  wire logic                      i_sys_rst,
  input  wire logic                      i_psel,
  input  wire logic                      i_penable,
  input  wire logic                      i_pwrite,
  input  wire logic [11:0]               i_paddr,
  input  wire logic [31:0]               i_pwdata,
  output logic      [31:0]               o_prdata,
  output logic                           o_pready,
  output logic                           o_pslverr,
  input  wire logic                      i_rx_valid,
  input  wire logic [`LCS_TYPE_W-1:0]    i_rx_type,
  input  wire lcs_addr_t                 i_rx_src,
  input  wire lcs_prio_t                 i_rx_prio,
  input  wire logic                      i_rx_seq,
  output logic                           o_rx_done,
  output logic                           o_rx_dup,
  input  wire logic                      i_tx_req,
  input  wire logic                      i_tx_resp,
  input  wire logic [`LCS_TYPE_W-1:0]    i_tx_type,
  input  wire lcs_addr_t                 i_tx_dest,
  input  wire lcs_prio_t                 i_tx_prio,
  input  wire lcs_sap_t                  i_tx_ssap,
  input  wire logic                      i_tx_seq,
  input  wire logic [`LCS_STAT_W-1:0]    i_tx_status,
  output logic                           o_tx_ready,
  output logic                           o_tx_valid,
  output logic [`LCS_TYPE_W:0]           o_tx_type_field,
  output logic [`LCS_SAP_W:0]            o_tx_ssap_field,
  output lcs_addr_t                      o_tx_dest,
  output lcs_prio_t                      o_tx_prio,
  output logic [`LCS_NUM_INIT-1:0]       o_init_active,
  output logic [`LCS_NUM_RESP-1:0]       o_sem_busy
);

  // ==========
  // APB decode
  logic       pready_ff;
  logic       apb_acc;
  logic       wr_done;
  logic       rd_done;
  logic [3:0] rgn;
  logic [1:0] idx;
  logic [1:0] wsel;
  logic       aligned;

  assign apb_acc = i_psel & i_penable & ~pready_ff;
  assign wr_done = i_psel & i_penable & pready_ff & i_pwrite;
  assign rd_done = i_psel & i_penable & pready_ff & ~i_pwrite;
  assign rgn     = i_paddr[11:8];
  assign idx     = i_paddr[5:4];
  assign wsel    = i_paddr[3:2];
  assign aligned = (i_paddr[1:0] == 2'h0) & (i_paddr[7:6] == 2'h0);

  // ==========
  // global stores, one instance per station
  logic [`LCS_TYPE_W-1:0] hist_type_ff;
  lcs_addr_t              hist_src_ff;
  lcs_prio_t              hist_prio_ff;
  logic                   hist_seq_ff;
  logic                   hist_valid_ff;
  logic [`LCS_STAT_W-1:0] last_stat_ff;
  logic                   last_stat_valid_ff;
  logic                   rx_match;

  assign rx_match = hist_valid_ff & (i_rx_type == hist_type_ff)
                  & (i_rx_src == hist_src_ff) & (i_rx_prio == hist_prio_ff)
                  & (i_rx_seq == hist_seq_ff);

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      hist_type_ff  <= '0;
      hist_src_ff   <= '0;
      hist_prio_ff  <= '0;
      hist_seq_ff   <= 1'b0;
      hist_valid_ff <= 1'b0;
    end else if (i_rx_valid) begin
      hist_type_ff  <= i_rx_type;
      hist_src_ff   <= i_rx_src;
      hist_prio_ff  <= i_rx_prio;
      hist_seq_ff   <= i_rx_seq;
      hist_valid_ff <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_rx_done <= 1'b0;
      o_rx_dup  <= 1'b0;
    end else begin
      o_rx_done <= i_rx_valid;
      o_rx_dup  <= i_rx_valid & rx_match;
    end
  end

  // ==========
  // transmit sequencing
  lcs_tx_state_t            state_ff;
  lcs_tx_state_t            nxt_state;
  lcs_addr_t                sweep_ff;
  lcs_addr_t                tx_dest_ff;
  lcs_prio_t                tx_prio_ff;
  logic [`LCS_TYPE_W-1:0]   tx_type_ff;
  lcs_sap_t                 tx_ssap_ff;
  logic                     tx_accept;
  logic                     mem_we;
  lcs_addr_t                mem_waddr;
  logic [`LCS_NUM_PRIO-1:0] mem_wdata;
  logic [`LCS_NUM_PRIO-1:0] mem_rdata;
  logic                     next_seq;

  assign tx_accept = (state_ff == TX_IDLE) & i_tx_req;
  // one boolean bit per priority lane
  assign next_seq  = ~mem_rdata[tx_prio_ff];

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      TX_INIT: begin
        if (sweep_ff == lcs_addr_t'(`LCS_NUM_STN - 1)) begin
          nxt_state = TX_IDLE;
        end
      end
      TX_IDLE: begin
        if (tx_accept & ~i_tx_resp) begin
          nxt_state = TX_READ;
        end
      end
      TX_READ: nxt_state = TX_IDLE;
      default: nxt_state = TX_INIT;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_ff   <= TX_INIT;
      o_tx_ready <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      o_tx_ready <= (nxt_state == TX_IDLE);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      sweep_ff <= '0;
    end else if (state_ff == TX_INIT) begin
      sweep_ff <= sweep_ff + lcs_addr_t'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      tx_dest_ff <= '0;
      tx_prio_ff <= '0;
      tx_type_ff <= '0;
      tx_ssap_ff <= '0;
    end else if (tx_accept) begin
      tx_dest_ff <= i_tx_dest;
      tx_prio_ff <= i_tx_prio;
      tx_type_ff <= i_tx_type;
      tx_ssap_ff <= i_tx_ssap;
    end
  end

  // clear every station during the sweep after reset, then write back the bit just sent
  always_comb begin
    mem_we    = 1'b0;
    mem_waddr = sweep_ff;
    mem_wdata = `LCS_SEQ_INIT;
    if (state_ff == TX_INIT) begin
      mem_we = 1'b1;
    end else if (state_ff == TX_READ) begin
      mem_we    = 1'b1;
      mem_waddr = tx_dest_ff;
      mem_wdata = mem_rdata;
      mem_wdata[tx_prio_ff] = next_seq;
    end
  end

  lcs_seq_mem u_seq_mem (
    .i_clk   (i_clk),
    .i_we    (mem_we),
    .i_waddr (mem_waddr),
    .i_wdata (mem_wdata),
    .i_re    (tx_accept),
    .i_raddr (i_tx_dest),
    .o_rdata (mem_rdata)
  );

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_tx_valid      <= 1'b0;
      o_tx_type_field <= '0;
      o_tx_ssap_field <= '0;
      o_tx_dest       <= '0;
      o_tx_prio       <= '0;
    end else if (state_ff == TX_READ) begin
      o_tx_valid      <= 1'b1;
      o_tx_type_field <= {tx_type_ff, next_seq};
      o_tx_ssap_field <= {tx_ssap_ff, `LCS_CR_COMMAND};
      o_tx_dest       <= tx_dest_ff;
      o_tx_prio       <= tx_prio_ff;
    end else if (tx_accept & i_tx_resp) begin
      o_tx_valid      <= 1'b1;
      o_tx_type_field <= {i_tx_type, i_tx_seq};
      o_tx_ssap_field <= {i_tx_ssap, `LCS_CR_RESPONSE};
      o_tx_dest       <= i_tx_dest;
      o_tx_prio       <= i_tx_prio;
    end else begin
      o_tx_valid      <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      last_stat_ff       <= '0;
      last_stat_valid_ff <= 1'b0;
    end else if (tx_accept & i_tx_resp) begin
      last_stat_ff       <= i_tx_status;
      last_stat_valid_ff <= 1'b1;
    end
  end

  // ========================================================================
  // initiator machines
  logic [31:0] init_ctx_rd  [`LCS_NUM_INIT];
  logic [31:0] init_cfg_rd  [`LCS_NUM_INIT];
  logic [31:0] init_len_rd  [`LCS_NUM_INIT];

  for (genvar gi = 0; gi < `LCS_NUM_INIT; gi++) begin : g_init
    lcs_sap_t                            ctx_ssap_ff;
    lcs_sap_t                            ctx_dsap_ff;
    lcs_addr_t                           ctx_ra_ff;
    logic [`LCS_SC_W-1:0]                ctx_sc_ff;
    lcs_prio_t                           ctx_prio_ff;
    logic                                ctx_valid_ff;
    logic [`LCS_NUM_SVC-1:0]             en_ff;
    logic [`LCS_NUM_SVC*`LCS_LEN_W-1:0]  len_ff;
    logic                                hit;

    assign hit = wr_done & aligned & (rgn == `LCS_RGN_INIT)
               & (idx == `LCS_IDX_W'(gi));

    always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
        ctx_ssap_ff  <= '0;
        ctx_dsap_ff  <= '0;
        ctx_ra_ff    <= '0;
        ctx_sc_ff    <= '0;
        ctx_prio_ff  <= '0;
        ctx_valid_ff <= 1'b0;
      end else if (hit & (wsel == `LCS_REG_CTX)) begin
        ctx_ssap_ff  <= i_pwdata[`LCS_SAP_W-1:0];
        ctx_dsap_ff  <= i_pwdata[`LCS_CTX_DSAP_LSB +: `LCS_SAP_W];
        ctx_ra_ff    <= i_pwdata[`LCS_CTX_RA_LSB +: `LCS_ADR_W];
        ctx_sc_ff    <= i_pwdata[`LCS_CTX_SC_LSB +: `LCS_SC_W];
        // priority is the even class: class 2k and 2k+1 share lane k
        ctx_prio_ff  <= i_pwdata[`LCS_CTX_SC_LSB + 1 +: `LCS_PRIO_W];
        ctx_valid_ff <= 1'b1;
      end else if (hit & (wsel == `LCS_REG_CTXCLR)) begin
        ctx_ssap_ff  <= '0;
        ctx_dsap_ff  <= '0;
        ctx_ra_ff    <= '0;
        ctx_sc_ff    <= '0;
        ctx_prio_ff  <= '0;
        ctx_valid_ff <= 1'b0;
      end
    end

    always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
        en_ff  <= '0;
        len_ff <= '0;
      end else begin
        if (hit & (wsel == `LCS_REG_ICFG)) begin
          en_ff <= i_pwdata[`LCS_NUM_SVC-1:0];
        end
        if (hit & (wsel == `LCS_REG_ILEN)) begin
          len_ff <= i_pwdata[`LCS_NUM_SVC*`LCS_LEN_W-1:0];
        end
      end
    end

    always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
        o_init_active[gi] <= 1'b0;
      end else begin
        o_init_active[gi] <= |en_ff;
      end
    end

    assign init_ctx_rd[gi] = {ctx_valid_ff, 1'b0, ctx_prio_ff, 1'b0,
                              ctx_sc_ff, ctx_ra_ff, 1'b0, ctx_dsap_ff,
                              1'b0, ctx_ssap_ff};
    assign init_cfg_rd[gi] = {28'h0000000, |en_ff, en_ff};
    assign init_len_rd[gi] = {8'h00, len_ff};
  end

  // ========================================================================
  // responder machines
  logic [31:0] resp_cfg_rd [`LCS_NUM_RESP];
  logic [31:0] resp_len_rd [`LCS_NUM_RESP];
  logic        sem_rd      [`LCS_NUM_RESP];

  for (genvar gr = 0; gr < `LCS_NUM_RESP; gr++) begin : g_resp
    logic [`LCS_NUM_SVC-1:0]             en_ff;
    logic [`LCS_NUM_SVC*`LCS_LEN_W-1:0]  len_ff;
    logic [`LCS_AREA_W-1:0]              area_ff;
    lcs_sap_t                            notify_sap_ff;
    logic                                sem_ff;
    logic                                sel;

    assign sel = aligned & (rgn == `LCS_RGN_RESP)
               & (idx == `LCS_IDX_W'(gr));

    always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
        en_ff         <= '0;
        len_ff        <= '0;
        area_ff       <= '0;
        notify_sap_ff <= '0;
      end else begin
        if (wr_done & sel & (wsel == `LCS_REG_RCFG)) begin
          en_ff         <= i_pwdata[`LCS_NUM_SVC-1:0];
          area_ff       <= i_pwdata[`LCS_RCFG_AREA_LSB +: `LCS_AREA_W];
          notify_sap_ff <= i_pwdata[`LCS_RCFG_REPLY_NOTIFY_ACCESS_POINT_LSB +: `LCS_SAP_W];
        end
        if (wr_done & sel & (wsel == `LCS_REG_RLEN)) begin
          len_ff <= i_pwdata[`LCS_NUM_SVC*`LCS_LEN_W-1:0];
        end
      end
    end

    // read tests and sets, write of 0 releases
    always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
        sem_ff <= 1'b0;
      end else if (rd_done & sel & (wsel == `LCS_REG_SEM)) begin
        sem_ff <= 1'b1;
      end else if (wr_done & sel & (wsel == `LCS_REG_SEM) & ~i_pwdata[0]) begin
        sem_ff <= 1'b0;
      end
    end

    always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
        o_sem_busy[gr] <= 1'b0;
      end else begin
        o_sem_busy[gr] <= sem_ff;
      end
    end

    assign resp_cfg_rd[gr] = {9'h000, notify_sap_ff, 4'h0, area_ff,
                              5'h00, en_ff};
    assign resp_len_rd[gr] = {8'h00, len_ff};
    assign sem_rd[gr]      = sem_ff;
  end

  // ========================================================================
  // read mux and APB answer
  logic [31:0] rd_data;
  logic        rd_err;

  always_comb begin
    rd_data = 32'h00000000;
    rd_err  = ~aligned;
    case (rgn)
      `LCS_RGN_GLOBAL: begin
        rd_err = rd_err | (idx != 2'h0);
        case (wsel)
          `LCS_OFF_STATUS:
            rd_data = {29'h00000000, hist_valid_ff, o_tx_ready,
                       state_ff == TX_INIT};
          `LCS_OFF_RXHIST:
            rd_data = {hist_valid_ff, 12'h000, hist_type_ff, hist_src_ff,
                       1'b0, hist_prio_ff, hist_seq_ff};
          `LCS_OFF_LASTSTAT:
            rd_data = {last_stat_valid_ff, 23'h000000, last_stat_ff};
          default: rd_err = 1'b1;
        endcase
      end
      `LCS_RGN_INIT: begin
        case (wsel)
          `LCS_REG_CTX:    rd_data = init_ctx_rd[idx];
          `LCS_REG_CTXCLR: rd_data = 32'h00000000;
          `LCS_REG_ICFG:   rd_data = init_cfg_rd[idx];
          default:         rd_data = init_len_rd[idx];
        endcase
      end
      `LCS_RGN_RESP: begin
        case (wsel)
          `LCS_REG_RCFG: rd_data = resp_cfg_rd[idx];
          `LCS_REG_RLEN: rd_data = resp_len_rd[idx];
          `LCS_REG_SEM:  rd_data = {31'h00000000, sem_rd[idx]};
          default:       rd_err  = 1'b1;
        endcase
      end
      default: rd_err = 1'b1;
    endcase
  end

  // one wait state: answer in the second access cycle
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      pready_ff <= 1'b0;
      o_prdata  <= 32'h00000000;
      o_pslverr <= 1'b0;
    end else begin
      pready_ff <= apb_acc;
      o_prdata  <= (apb_acc & ~i_pwrite & ~rd_err) ? rd_data : 32'h00000000;
      o_pslverr <= apb_acc & rd_err;
    end
  end

  assign o_pready = pready_ff;

endmodule : lcs_top

// [testbench/lcs_monitor.sv]
// Purpose: port assertions for lcs_top
// Assumes: one clock, synchronous active high reset
// Notes:   bound to every lcs_top after the module
`timescale 1ns/1ps
`include "lcs_consts.svh"

module lcs_monitor
  import lcs_pkg::*;
(
  input wire logic                       i_clk,
  input wire logic                       i_sys_rst,
  input wire logic                       i_psel,
  input wire logic                       i_penable,
  input wire logic                       o_pready,
  input wire logic                       i_rx_valid,
  input wire logic                       o_rx_done,
  input wire logic                       o_rx_dup,
  input wire logic                       i_tx_req,
  input wire logic                       i_tx_resp,
  input wire logic [`LCS_TYPE_W-1:0]     i_tx_type,
  input wire lcs_addr_t                  i_tx_dest,
  input wire lcs_prio_t                  i_tx_prio,
  input wire logic                       i_tx_seq,
  input wire logic                       o_tx_ready,
  input wire logic                       o_tx_valid,
  input wire logic [`LCS_TYPE_W:0]       o_tx_type_field,
  input wire logic [`LCS_SAP_W:0]        o_tx_ssap_field,
  input wire lcs_addr_t                  o_tx_dest,
  input wire lcs_prio_t                  o_tx_prio,
  input wire logic [`LCS_NUM_INIT-1:0]   o_init_active,
  input wire logic [`LCS_NUM_RESP-1:0]   o_sem_busy
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  // ==========
  // frame side, reset, initiator activity and semaphore outputs
  logic acc;
  assign acc = i_psel && i_penable && o_pready;

  sequence s_cmd_take;
    i_tx_req && o_tx_ready && !i_tx_resp;
  endsequence
  sequence s_cmd_walk;
    !o_tx_ready ##1 (o_tx_valid && o_tx_ready && !o_tx_ssap_field[0]);
  endsequence

  property p_rx_done;
    i_rx_valid |=> o_rx_done;
  endproperty
  a_rx_done: assert property (p_rx_done)
    else $error("rx done missing");
  property p_dup;
    o_rx_dup |-> o_rx_done && $past(i_rx_valid);
  endproperty
  a_dup: assert property (p_dup)
    else $error("duplicate without frame");
  property p_cmd;
    s_cmd_take |=> s_cmd_walk;
  endproperty
  a_cmd: assert property (p_cmd)
    else $error("command frame walk wrong");
  property p_cmd_fields;
    s_cmd_take |-> ##2 (o_tx_dest == $past(i_tx_dest, 2)
      && o_tx_prio == $past(i_tx_prio, 2)
      && o_tx_type_field[7:1] == $past(i_tx_type, 2));
  endproperty
  a_cmd_fields: assert property (p_cmd_fields)
    else $error("command fields wrong");
  property p_resp;
    i_tx_req && o_tx_ready && i_tx_resp |=> o_tx_valid
      && o_tx_ssap_field[0] && o_tx_type_field[0] == $past(i_tx_seq);
  endproperty
  a_resp: assert property (p_resp)
    else $error("response frame wrong");
  property p_reset;
    $fell(i_sys_rst) |-> !o_tx_ready && o_sem_busy == 4'h0
      && o_init_active == 4'h0;
  endproperty
  a_reset: assert property (p_reset)
    else $error("state not cleared by reset");
  property p_init;
    $changed(o_init_active) |-> $past(acc) || $past(acc, 2);
  endproperty
  a_init: assert property (p_init)
    else $error("initiator activity changed alone");
  property p_sem;
    $changed(o_sem_busy) |-> $past(acc) || $past(acc, 2);
  endproperty
  a_sem: assert property (p_sem)
    else $error("semaphore changed alone");
endmodule : lcs_monitor

bind lcs_top lcs_monitor u_mon (.*);

// [testbench/lcs_mac_model.sv]
// Purpose: frame side partner of lcs_top
// Assumes: driven from the bench by task calls
// Notes:   released lines show the inverse of the last value
`timescale 1ns/1ps
`include "lcs_consts.svh"

module lcs_mac_model
  import lcs_pkg::*;
(
  input  wire logic                   i_clk,
  output logic                        o_rx_valid,
  output logic [`LCS_TYPE_W-1:0]      o_rx_type,
  output lcs_addr_t                   o_rx_src,
  output lcs_prio_t                   o_rx_prio,
  output logic                        o_rx_seq,
  input  wire logic                   i_rx_done,
  input  wire logic                   i_rx_dup,
  output logic                        o_tx_req,
  output logic                        o_tx_resp,
  output logic [`LCS_TYPE_W-1:0]      o_tx_type,
  output lcs_addr_t                   o_tx_dest,
  output lcs_prio_t                   o_tx_prio,
  output lcs_sap_t                    o_tx_ssap,
  output logic                        o_tx_seq,
  output logic [`LCS_STAT_W-1:0]      o_tx_status,
  input  wire logic                   i_tx_ready,
  input  wire logic                   i_tx_valid,
  input  wire logic [`LCS_TYPE_W:0]   i_tx_type_field,
  input  wire logic [`LCS_SAP_W:0]    i_tx_ssap_field
);
  initial begin
    {o_rx_valid, o_rx_type, o_rx_src, o_rx_prio, o_rx_seq} = '0;
    {o_tx_req, o_tx_resp, o_tx_type, o_tx_dest, o_tx_prio} = '0;
    {o_tx_ssap, o_tx_seq, o_tx_status} = '0;
  end

  // ==========
  // received frame: one cycle valid, answer one cycle later
  task automatic rx(input logic [17:0] f, output logic dup);
    @(posedge i_clk);
    o_rx_valid <= 1'b1;
    {o_rx_type, o_rx_src, o_rx_prio, o_rx_seq} <= f;
    @(posedge i_clk);
    o_rx_valid <= 1'b0;
    {o_rx_type, o_rx_src, o_rx_prio, o_rx_seq} <= ~f;
    @(posedge i_clk);
    dup = i_rx_done & i_rx_dup;
  endtask : rx

  // ==========
  // frame build: request held until ready, then wait for valid
  task automatic tx(input logic rs, input lcs_addr_t d, output logic [15:0] f);
    int n;
    @(posedge i_clk);
    {o_tx_req, o_tx_resp, o_tx_type, o_tx_dest} <= {1'b1, rs, 7'h11, d};
    {o_tx_prio, o_tx_ssap, o_tx_seq, o_tx_status} <= {2'h1, 7'h22, 1'b1, 8'h5A};
    n = 0;
    do @(posedge i_clk); while (i_tx_ready !== 1'b1 && ++n < 400);
    o_tx_req <= 1'b0;
    n = 0;
    do @(posedge i_clk); while (i_tx_valid !== 1'b1 && ++n < 8);
    f = {i_tx_type_field, i_tx_ssap_field};
  endtask : tx
endmodule : lcs_mac_model

// [testbench/lcs_top_tb.sv]
// Purpose: self-checking bench of lcs_top
// Assumes: APB master here, frame side in lcs_mac_model
// Notes:   run ends in test_done
`timescale 1ns/1ps
`include "lcs_consts.svh"

module lcs_top_tb
  import lcs_pkg::*;
;
  logic        i_clk, i_sys_rst, i_psel, i_penable, i_pwrite;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, r;
  logic        o_pready, o_pslverr, er, d;
  logic        i_rx_valid, i_rx_seq, o_rx_done, o_rx_dup;
  logic [6:0]  i_rx_type, i_tx_type;
  lcs_addr_t   i_rx_src, i_tx_dest;
  lcs_prio_t   i_rx_prio, i_tx_prio;
  logic        i_tx_req, i_tx_resp, i_tx_seq, o_tx_ready;
  logic        o_tx_valid;
  lcs_sap_t    i_tx_ssap;
  logic [7:0]  i_tx_status, o_tx_type_field, o_tx_ssap_field;
  logic [3:0]  o_init_active, o_sem_busy;
  logic [15:0] f;
  int          fails, compares, cycles, n;
  logic [11:0] ra [4] = '{12'h100, 12'h10C, 12'h210, 12'h214};
  logic [31:0] rv [4] = '{32'hA5A51234, 32'h00332211,
                          32'h00450A05, 32'h00665544};
  logic [17:0] fr [4] = '{18'h0, 18'h184E4, 18'h184E4, 18'h184E5};

  lcs_top dut (.*, .o_tx_dest(), .o_tx_prio());
  lcs_mac_model u_mac (
    .i_clk, .o_rx_valid(i_rx_valid), .o_rx_type(i_rx_type),
    .o_rx_src(i_rx_src), .o_rx_prio(i_rx_prio), .o_rx_seq(i_rx_seq),
    .i_rx_done(o_rx_done), .i_rx_dup(o_rx_dup), .o_tx_req(i_tx_req),
    .o_tx_resp(i_tx_resp), .o_tx_type(i_tx_type), .o_tx_dest(i_tx_dest),
    .o_tx_prio(i_tx_prio), .o_tx_ssap(i_tx_ssap), .o_tx_seq(i_tx_seq),
    .o_tx_status(i_tx_status), .i_tx_ready(o_tx_ready),
    .i_tx_valid(o_tx_valid), .i_tx_type_field(o_tx_type_field),
    .i_tx_ssap_field(o_tx_ssap_field)
  );

  // ==========
  // clock, timeout and verdict
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      test_done;
    end
  end
  task test_done;
    if (fails == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // ==========
  // apb master: hold request until pready is sampled high
  task automatic apb(input logic w, logic [11:0] a, logic [31:0] wd);
    n = 0;
    @(posedge i_clk);
    {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {2'b10, w, a, wd};
    @(posedge i_clk);
    i_penable <= 1'b1;
    do @(posedge i_clk); while (o_pready !== 1'b1 && ++n < 20);
    r = o_prdata;
    er = o_pslverr;
    {i_psel, i_penable} <= 2'b00;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), r, e);
  endtask : rd

  // ==========
  // main sequence
  initial begin
    {i_sys_rst, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = {1'b1, 47'h0};
    {fails, compares, cycles} = '0;
    repeat (4) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    rd(12'h000, 32'h1);
    while (o_tx_ready !== 1'b1 && n < 400) @(posedge i_clk) n++;
    rd(12'h000, 32'h2);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ra[i], rv[i]);
      rd(ra[i], rv[i]);
    end
    apb(1'b1, 12'h104, 32'h0);
    rd(12'h100, 32'h0);
    apb(1'b1, 12'h118, 32'h4);
    rd(12'h118, 32'hC);
    chk("active", {28'h0, o_init_active}, 32'h2);
    apb(1'b1, 12'h118, 32'h0);
    rd(12'h118, 32'h0);
    rd(12'h228, 32'h0);
    rd(12'h228, 32'h1);
    chk("sem", {28'h0, o_sem_busy}, 32'h4);
    apb(1'b1, 12'h228, 32'h0);
    rd(12'h228, 32'h0);
    apb(1'b0, 12'h20C, 32'h0);
    chk("slverr", {31'h0, er}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      u_mac.rx(fr[i], d);
      chk("dup", {31'h0, d}, {31'h0, i == 2});
    end
    rd(12'h004, 32'h800309C5);
    u_mac.tx(1'b0, 8'h05, f);
    chk("cmd", {16'h0, f}, 32'h2344);
    u_mac.tx(1'b0, 8'h05, f);
    chk("cmd", {16'h0, f}, 32'h2244);
    u_mac.tx(1'b1, 8'h05, f);
    chk("resp", {16'h0, f}, 32'h2345);
    rd(12'h008, 32'h8000005A);
    test_done;
  end
endmodule : lcs_top_tb
